// ==== inc/ssao_pkg.sv ====
// Shared constants and carrier types for the bus slave with alarm outputs
package ssao_pkg;
    localparam logic [5:0] ADDR_UPPER     = 6'h26;
    localparam logic [7:0] ALERT_RESP_CMD = 8'h19;
    localparam logic [7:0] HS_CODE_MASK   = 8'hF8;
    localparam logic [7:0] HS_CODE_VALUE  = 8'h08;
    localparam logic [7:0] HYST_RESET     = 8'h0A;
    localparam logic [2:0] CONSEC_MAX     = 3'h4;
    localparam int         TIMEOUT_MS     = 32;
    localparam int         LINK_PERIOD_NS = 125;
    localparam int         TIMEOUT_CYC    = TIMEOUT_MS * 1000000 / LINK_PERIOD_NS;
    localparam int         TMO_W          = 20;

    typedef enum logic [2:0] {
        SSAO_IDLE     = 3'b000,
        SSAO_ADDR     = 3'b001,
        SSAO_ADDR_ACK = 3'b010,
        SSAO_WR_BYTE  = 3'b011,
        SSAO_WR_ACK   = 3'b100,
        SSAO_RESP_TX  = 3'b101,
        SSAO_RESP_ACK = 3'b110,
        SSAO_IGNORE   = 3'b111
    } ssao_state_t;

    typedef struct packed {
        logic [7:0] local_temp;
        logic [7:0] remote_temp;
    } ssao_temps_t;

    typedef struct packed {
        logic [7:0] local_high;
        logic [7:0] local_low;
        logic [7:0] remote_high;
        logic [7:0] remote_low;
        logic [7:0] local_crit;
        logic [7:0] remote_crit;
    } ssao_limits_t;

    typedef struct packed {
        logic       alert_mask;
        logic       warning_pin_function_select;
        logic [1:0] consec_sel;
    } ssao_config_t;
endpackage

// ==== src/ssao_top.sv ====
// Bus slave engine, bus timeout, over-temperature and shared warning pin logic
// Summary of operation
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Acknowledge holds SDA low through high phase
// - High-speed code not acknowledged, filters switch
// - High-speed persists until STOP or timeout, then fast filters
// - Reset interface when line low 32 ms
// - On timeout release SDA, await START
// - Alarm low when temperature beyond alarm limit
// - Alarm clears below limit minus hysteresis
// - Hysteresis resets to ten degrees
// - Function select bit picks warning or alarm
// - Second alarm uses high limits with hysteresis
// - Warning on high or low limit violation
// - Warning after one to four consecutive violations
// - Warning on open remote diode
// - Mask bit keeps warning inactive
// - Address read releases warning when conditions cleared
// - Alert response acknowledged, own address returned
// - Returned last bit shows high or low cause
// - Arbitration winner clears, loser keeps warning
// - Bytes travel most significant bit first
// - Seven-bit address 1001100 or 1001101
module ssao_top
    import ssao_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         bus_sample_clk,
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe,
    input  wire logic         addr_sel,
    input  wire ssao_temps_t  temps,
    input  wire logic         conv_done,
    input  wire logic         remote_open,
    input  wire ssao_limits_t limits,
    input  wire ssao_config_t cfg,
    input  wire logic         status_pending,
    input  wire logic         hyst_wr,
    input  wire logic [7:0]   hyst_wdata,
    output logic              over_temp_alarm_n,
    output logic              shared_warning_pin_n,
    output logic              hs_mode
);
    // Internal clock domain: alarm pins and warning latch
    typedef struct packed {
        logic [7:0] hyst;
        logic       therm_loc, therm_rem, t2_loc, t2_rem;
        logic [2:0] consec;
        logic       alert, high_cause;
        logic       rd_s1, rd_s2, rd_p;
        logic       win_s1, win_s2, win_p;
        logic       therm_n, warn_n, alert_lvl;
    } ssao_core_t;
    typedef struct packed {
        logic             scl_s1, scl_s2, scl_h, scl_f, scl_p;
        logic             sda_s1, sda_s2, sda_h, sda_f, sda_p;
        logic             strap_s1, strap_s2, alert_s1, alert_s2, cause_s1, cause_s2;
        ssao_state_t      state;
        logic [3:0]       bitcnt;
        logic [7:0]       shreg;
        logic [7:0]       txreg;
        logic             is_read, is_resp, busy, hs, oe, win_pend, rd_tgl, win_tgl;
        logic [TMO_W-1:0] tmo_cnt;
    } ssao_link_t;
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYCLES - 1);
    ssao_core_t c_q, c_d;
    ssao_link_t l_q, l_d;

    // Hysteresis comparator: set at or above limit, clear below limit minus hysteresis.
    // Nine-bit sum keeps a large hysteresis from wrapping into a false release.
    function automatic logic hyst_step(input logic cur, input logic [7:0] t,
                                       input logic [7:0] lim, input logic [7:0] hy);
        logic r;
        r = cur;
        // set at limit, release below hysteresis
        if (t >= lim) begin
            r = 1'b1;
        end else if (({1'b0, t} + {1'b0, hy}) < {1'b0, lim}) begin
            r = 1'b0;
        end
        return r;
    endfunction

    logic       viol_high, viol_low, viol_now;
    logic [2:0] consec_inc;
    logic       rd_evt, win_evt;
    always_comb begin
        c_d = c_q;
        viol_high = (temps.local_temp >= limits.local_high)
                  | (temps.remote_temp >= limits.remote_high);
        viol_low  = (temps.local_temp < limits.local_low)
                  | (temps.remote_temp < limits.remote_low);
        viol_now  = viol_high | viol_low | remote_open;
        consec_inc = (c_q.consec == CONSEC_MAX) ? CONSEC_MAX : c_q.consec + 3'h1;

        c_d.rd_s1  = l_q.rd_tgl;
        c_d.rd_s2  = c_q.rd_s1;
        c_d.rd_p   = c_q.rd_s2;
        c_d.win_s1 = l_q.win_tgl;
        c_d.win_s2 = c_q.win_s1;
        c_d.win_p  = c_q.win_s2;
        rd_evt  = c_q.rd_s2 ^ c_q.rd_p;
        win_evt = c_q.win_s2 ^ c_q.win_p;

        if (hyst_wr) begin
            c_d.hyst = hyst_wdata;
        end

        if (rd_evt && !viol_now && !status_pending) begin
            c_d.alert = 1'b0;
        end
        if (win_evt) begin
            c_d.alert = 1'b0;
        end

        if (conv_done) begin
            c_d.therm_loc = hyst_step(c_q.therm_loc, temps.local_temp,
                                      limits.local_crit, c_q.hyst);
            c_d.therm_rem = hyst_step(c_q.therm_rem, temps.remote_temp,
                                      limits.remote_crit, c_q.hyst);
            c_d.t2_loc = hyst_step(c_q.t2_loc, temps.local_temp,
                                   limits.local_high, c_q.hyst);
            c_d.t2_rem = hyst_step(c_q.t2_rem, temps.remote_temp,
                                   limits.remote_high, c_q.hyst);
            if (viol_now) begin
                c_d.consec = consec_inc;
                // A new violation beats a release in the same cycle
                if (consec_inc >= ({1'b0, cfg.consec_sel} + 3'h1)) begin
                    c_d.alert      = 1'b1;
                    c_d.high_cause = viol_high;
                end
            end else begin
                c_d.consec = 3'h0;
            end
        end

        c_d.therm_n = ~(c_q.therm_loc | c_q.therm_rem);
        if (cfg.warning_pin_function_select) begin
            c_d.warn_n = ~(c_q.t2_loc | c_q.t2_rem);
        end else begin
            c_d.warn_n = ~(c_q.alert & ~cfg.alert_mask);
        end
        c_d.alert_lvl = c_q.alert & ~cfg.alert_mask & ~cfg.warning_pin_function_select;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            c_q      <= '0;
            c_q.hyst <= HYST_RESET;
            c_q.therm_n <= 1'b1;
            c_q.warn_n  <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end
    // Link domain: reset arrives through a two-stage synchroniser
    logic rst_l_s1, rst_l;
    always_ff @(posedge bus_sample_clk) begin
        rst_l_s1 <= reset;
        rst_l    <= rst_l_s1;
    end
    logic       st_evt, sp_evt, rise, fall, tmo;
    logic [6:0] own_addr;
    always_comb begin
        l_d = l_q;
        l_d.scl_s1 = scl_i;
        l_d.scl_s2 = l_q.scl_s1;
        l_d.scl_h  = l_q.scl_s2;
        l_d.sda_s1 = sda_i;
        l_d.sda_s2 = l_q.sda_s1;
        l_d.sda_h  = l_q.sda_s2;
        if (l_q.hs || (l_q.scl_s2 == l_q.scl_h)) begin
            l_d.scl_f = l_q.scl_s2;
        end
        if (l_q.hs || (l_q.sda_s2 == l_q.sda_h)) begin
            l_d.sda_f = l_q.sda_s2;
        end
        l_d.scl_p    = l_q.scl_f;
        l_d.sda_p    = l_q.sda_f;
        l_d.strap_s1 = addr_sel;
        l_d.strap_s2 = l_q.strap_s1;
        l_d.alert_s1 = c_q.alert_lvl;
        l_d.alert_s2 = l_q.alert_s1;
        l_d.cause_s1 = c_q.high_cause;
        l_d.cause_s2 = l_q.cause_s1;

        own_addr = {ADDR_UPPER, l_q.strap_s2};
        st_evt = l_q.scl_f & l_q.scl_p & l_q.sda_p & ~l_q.sda_f;
        sp_evt = l_q.scl_f & l_q.scl_p & ~l_q.sda_p & l_q.sda_f;
        rise   = ~l_q.scl_p & l_q.scl_f;
        fall   = l_q.scl_p & ~l_q.scl_f;
        tmo    = l_q.busy && (l_q.tmo_cnt == TMO_LAST);
        if (l_q.busy && (!l_q.scl_f || !l_q.sda_f)) begin
            l_d.tmo_cnt = l_q.tmo_cnt + TMO_W'(1);
        end else begin
            l_d.tmo_cnt = '0;
        end

        if (tmo) begin
            l_d.state    = SSAO_IDLE;
            l_d.busy     = 1'b0;
            l_d.oe       = 1'b0;
            l_d.hs       = 1'b0;
            l_d.win_pend = 1'b0;
            l_d.tmo_cnt  = '0;
        end else if (sp_evt) begin
            l_d.hs    = 1'b0;
            l_d.state = SSAO_IDLE;
            l_d.busy  = 1'b0;
            l_d.oe    = 1'b0;
            if (l_q.win_pend) begin
                l_d.win_tgl = ~l_q.win_tgl;
            end
            l_d.win_pend = 1'b0;
        end else if (st_evt) begin
            l_d.state   = SSAO_ADDR;
            l_d.bitcnt  = 4'h0;
            l_d.busy    = 1'b1;
            l_d.oe      = 1'b0;
            l_d.is_read = 1'b0;
            l_d.is_resp = 1'b0;
            // A repeated start ends the response command as well
            if (l_q.win_pend) begin
                l_d.win_tgl = ~l_q.win_tgl;
            end
            l_d.win_pend = 1'b0;
        end else begin
            case (l_q.state)
                SSAO_ADDR, SSAO_WR_BYTE: begin
                    if (rise) begin
                        l_d.shreg  = {l_q.shreg[6:0], l_q.sda_f};
                        l_d.bitcnt = l_q.bitcnt + 4'h1;
                    end else if (fall && l_q.bitcnt == 4'h8) begin
                        if (l_q.state == SSAO_WR_BYTE) begin
                            l_d.oe    = 1'b1;
                            l_d.state = SSAO_WR_ACK;
                        end else if ((l_q.shreg & HS_CODE_MASK) == HS_CODE_VALUE) begin
                            l_d.hs    = 1'b1;
                            l_d.state = SSAO_IGNORE;
                        end else if (l_q.shreg[7:1] == own_addr) begin
                            l_d.oe      = 1'b1;
                            l_d.is_read = l_q.shreg[0];
                            l_d.state   = SSAO_ADDR_ACK;
                        end else if (l_q.shreg == ALERT_RESP_CMD && l_q.alert_s2) begin
                            l_d.oe      = 1'b1;
                            l_d.is_resp = 1'b1;
                            l_d.state   = SSAO_ADDR_ACK;
                        end else begin
                            l_d.state = SSAO_IGNORE;
                        end
                    end
                end
                SSAO_ADDR_ACK: begin
                    if (fall) begin
                        l_d.bitcnt = 4'h0;
                        l_d.oe     = 1'b0;
                        if (l_q.is_resp) begin
                            l_d.txreg = {own_addr, l_q.cause_s2};
                            l_d.oe    = ~own_addr[6];
                            l_d.state = SSAO_RESP_TX;
                        end else if (l_q.is_read) begin
                            // Register reads are served elsewhere; line stays released
                            l_d.rd_tgl = ~l_q.rd_tgl;
                            l_d.state  = SSAO_IGNORE;
                        end else begin
                            l_d.state = SSAO_WR_BYTE;
                        end
                    end
                end
                SSAO_WR_ACK: begin
                    if (fall) begin
                        l_d.oe     = 1'b0;
                        l_d.bitcnt = 4'h0;
                        l_d.state  = SSAO_WR_BYTE;
                    end
                end
                SSAO_RESP_TX: begin
                    if (rise) begin
                        if (l_q.txreg[7] && !l_q.sda_f) begin
                            l_d.oe    = 1'b0;
                            l_d.state = SSAO_IGNORE;
                        end else begin
                            l_d.bitcnt = l_q.bitcnt + 4'h1;
                        end
                    end else if (fall) begin
                        l_d.txreg = {l_q.txreg[6:0], 1'b0};
                        if (l_q.bitcnt == 4'h8) begin
                            l_d.oe    = 1'b0;
                            l_d.state = SSAO_RESP_ACK;
                        end else begin
                            l_d.oe = ~l_q.txreg[6];
                        end
                    end
                end
                SSAO_RESP_ACK: begin
                    // master ack or nack both end it
                    if (rise) begin
                        l_d.win_pend = 1'b1;
                        l_d.state    = SSAO_IGNORE;
                    end
                end
                SSAO_IDLE, SSAO_IGNORE: begin
                    l_d.oe = 1'b0;
                end
                default: begin
                    l_d.state = SSAO_IDLE;
                    l_d.oe    = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge bus_sample_clk) begin
        if (rst_l) begin
            l_q       <= '0;
            l_q.state <= SSAO_IDLE;
            l_q.scl_f <= 1'b1;
            l_q.scl_p <= 1'b1;
            l_q.sda_f <= 1'b1;
            l_q.sda_p <= 1'b1;
        end else begin
            l_q <= l_d;
        end
    end

    // Open-drain: the pad only ever pulls low
    assign sda_o                = 1'b0;
    assign sda_oe               = l_q.oe;
    assign hs_mode              = l_q.hs;
    assign over_temp_alarm_n    = c_q.therm_n;
    assign shared_warning_pin_n = c_q.warn_n;
endmodule

// ==== bench/ssao_bus_master.sv ====
// Bus master model that bit-bangs SCL and pulls SDA low
module ssao_bus_master (
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int H = 1250;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic start();
        #(H/2) sda_oe = 1'b0;
        #(H/2) scl = 1'b1;
        #H sda_oe = 1'b1;
        #H scl = 1'b0;
    endtask
    task automatic stop();
        #(H/2) sda_oe = 1'b1;
        #(H/2) scl = 1'b1;
        #H sda_oe = 1'b0;
        #H;
    endtask
    // Data changes mid-low so the slave sees a clean hold time
    task automatic bit_io(input logic b, output logic r);
        #(H/2) sda_oe = !b;
        #(H/2) scl = 1'b1;
        #H r = sda;
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, r);
    endtask
endmodule

// ==== bench/ssao_top_checker.sv ====
// Concurrent checks on the bus slave and alarm pins
module ssao_top_checker
    import ssao_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic         ref_clk,
    input wire logic         reset,
    input wire logic         bus_sample_clk,
    input wire logic         scl_i,
    input wire logic         sda_i,
    input wire logic         sda_o,
    input wire logic         sda_oe,
    input wire ssao_temps_t  temps,
    input wire logic         conv_done,
    input wire ssao_limits_t limits,
    input wire ssao_config_t cfg,
    input wire logic         hyst_wr,
    input wire logic [7:0]   hyst_wdata,
    input wire logic         over_temp_alarm_n,
    input wire logic         shared_warning_pin_n,
    input wire logic         hs_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]     hy_q;
    logic [TMO_W:0] lo_q;
    logic           ot_hi;
    logic           ot_lo;
    logic           w2_hi;
    // Hysteresis is only visible through its write port
    always_ff @(posedge ref_clk) begin
        if (reset) hy_q <= HYST_RESET;
        else if (hyst_wr) hy_q <= hyst_wdata;
    end
    // Link cycles with a line low; an idle bus clears it
    always_ff @(posedge bus_sample_clk) begin
        if (reset || (scl_i && sda_i)) lo_q <= '0;
        else if (!(&lo_q)) lo_q <= lo_q + 1'b1;
    end
    assign ot_hi = temps.local_temp >= limits.local_crit
                || temps.remote_temp >= limits.remote_crit;
    assign ot_lo = 9'(temps.local_temp) + 9'(hy_q) < 9'(limits.local_crit)
                && 9'(temps.remote_temp) + 9'(hy_q) < 9'(limits.remote_crit);
    assign w2_hi = cfg.warning_pin_function_select
                && (temps.local_temp >= limits.local_high
                || temps.remote_temp >= limits.remote_high);
    sequence s_masked;
        (cfg.alert_mask && !cfg.warning_pin_function_select) [*3];
    endsequence
    sequence s_hs_enter;
        $rose(hs_mode);
    endsequence
    a_crit_sets: assert property (@(posedge ref_clk) disable iff (reset)
        conv_done && ot_hi |-> ##2 !over_temp_alarm_n) else $error("alarm not set");
    a_crit_clears: assert property (@(posedge ref_clk) disable iff (reset)
        conv_done && ot_lo |-> ##2 over_temp_alarm_n) else $error("alarm not cleared");
    a_alarm2_sets: assert property (@(posedge ref_clk) disable iff (reset)
        conv_done && w2_hi |-> ##2 !shared_warning_pin_n) else $error("alarm2 not set");
    a_mask_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        s_masked |-> shared_warning_pin_n) else $error("masked warning active");
    a_oe_steady: assert property (@(posedge bus_sample_clk) disable iff (reset)
        scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("sda moved, scl high");
    a_tmo_release: assert property (@(posedge bus_sample_clk) disable iff (reset)
        int'(lo_q) > TIMEOUT_CYCLES + 8 |-> !sda_oe && !hs_mode) else $error("no timeout");
    a_hs_noack: assert property (@(posedge bus_sample_clk) disable iff (reset)
        s_hs_enter |-> !sda_oe [*8]) else $error("hs code acknowledged");
    a_sda_zero: assert property (@(posedge ref_clk) disable iff (reset)
        sda_o == 1'b0) else $error("sda data not low");
endmodule
bind ssao_top ssao_top_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .ref_clk(ref_clk), .reset(reset), .bus_sample_clk(bus_sample_clk),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .temps(temps),
    .conv_done(conv_done), .limits(limits), .cfg(cfg), .hyst_wr(hyst_wr),
    .hyst_wdata(hyst_wdata), .over_temp_alarm_n(over_temp_alarm_n),
    .shared_warning_pin_n(shared_warning_pin_n), .hs_mode(hs_mode));

// ==== bench/ssao_top_test.sv ====
// Self-checking bench for the bus slave with alarm outputs
module ssao_top_test
    import ssao_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [7:0] l; logic [7:0] r; logic ot; logic wn;} ssao_row_t;
    localparam ssao_row_t ROWS [6] = '{'{8'h20, 8'h20, 1'b1, 1'b1},
        '{8'h50, 8'h20, 1'b0, 1'b0}, '{8'h47, 8'h20, 1'b0, 1'b0},
        '{8'h45, 8'h20, 1'b1, 1'b0}, '{8'h20, 8'h60, 1'b0, 1'b0},
        '{8'h20, 8'h20, 1'b1, 1'b0}};
    localparam logic [7:0] OWN_W = {ADDR_UPPER, 2'b00};
    logic ref_clk = 1'b0, link_clk = 1'b0, reset = 1'b1, scl, m_oe, dut_oe, sda_o;
    logic rival_oe = 1'b0, conv_done = 1'b0, remote_open = 1'b0, status_pending = 1'b0;
    logic addr_sel = 1'b0;
    logic hyst_wr = 1'b0, ot_n, warn_n, hs_mode, ack;
    logic [7:0] hyst_wdata = 8'h02, rd;
    ssao_temps_t  temps = 16'h2020;
    ssao_limits_t limits = 48'h40_10_48_10_50_60;
    ssao_config_t cfg = 4'h0;
    int error_cnt = 0, checks = 0, cyc = 0;
    wire logic sda_w;
    // Pull-up: the wire is low whenever any party drives it
    assign sda_w = !(m_oe || dut_oe || rival_oe);
    initial forever #5 ref_clk = !ref_clk;
    initial begin
        #37;
        forever #62.5 link_clk = !link_clk;
    end
    ssao_top #(.TIMEOUT_CYCLES(200)) uut (.ref_clk(ref_clk), .reset(reset),
        .bus_sample_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(dut_oe), .addr_sel(addr_sel), .temps(temps), .conv_done(conv_done),
        .remote_open(remote_open), .limits(limits), .cfg(cfg),
        .status_pending(status_pending), .hyst_wr(hyst_wr), .hyst_wdata(hyst_wdata),
        .over_temp_alarm_n(ot_n), .shared_warning_pin_n(warn_n), .hs_mode(hs_mode));
    ssao_bus_master bm (.scl(scl), .sda_oe(m_oe), .sda(sda_w));
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic conv(input logic [7:0] l, input logic [7:0] r);
        temps = {l, r};
        conv_done = 1'b1;
        tick(1);
        conv_done = 1'b0;
        tick(3);
    endtask
    task automatic addr_rd(input logic [7:0] a);
        bm.start();
        bm.wbyte(a, ack);
        bm.stop();
        tick(10);
    endtask
    task automatic rel();
        conv(8'h20, 8'h20);
        addr_rd(OWN_W | 8'h01);
    endtask
    task automatic alert(output logic [7:0] d);
        bm.start();
        bm.wbyte(ALERT_RESP_CMD, ack);
        bm.rbyte(1'b0, d);
        bm.stop();
        tick(10);
    endtask
    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 95000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        // One extra link edge so the link state is defined before checks start
        repeat (4) @(posedge link_clk);
        tick(1);
        reset = 1'b0;
        chk({ot_n, warn_n, dut_oe, hs_mode}, 8'h0C);
        for (int i = 0; i < 6; i++) begin
            conv(ROWS[i].l, ROWS[i].r);
            chk(ot_n, ROWS[i].ot);
            chk(warn_n, ROWS[i].wn);
        end
        $display("table done");
        addr_rd(8'h90);
        chk(ack, 1'b0);
        bm.start();
        for (int i = 0; i < 3; i++) begin
            bm.wbyte(i == 0 ? OWN_W : 8'hA5, ack);
            chk(ack, 1'b1);
        end
        bm.stop();
        chk(warn_n, 1'b0);
        $display("write done");
        fork
            alert(rd);
            begin
                #26875 rival_oe = 1'b1;
                #2500 rival_oe = 1'b0;
            end
        join
        chk({ack, rd}, 9'h17F);
        chk(warn_n, 1'b0);
        alert(rd);
        chk(rd, OWN_W | 8'h01);
        chk(warn_n, 1'b1);
        alert(rd);
        chk(ack, 1'b0);
        conv(8'h08, 8'h20);
        alert(rd);
        chk({ack, rd}, {1'b1, OWN_W});
        $display("alert done");
        conv(8'h45, 8'h20);
        status_pending = 1'b1;
        rel();
        chk({ack, warn_n}, 8'h02);
        status_pending = 1'b0;
        rel();
        chk(warn_n, 1'b1);
        cfg.alert_mask = 1'b1;
        conv(8'h45, 8'h20);
        chk(warn_n, 1'b1);
        cfg.alert_mask = 1'b0;
        rel();
        remote_open = 1'b1;
        conv(8'h20, 8'h20);
        chk(warn_n, 1'b0);
        remote_open = 1'b0;
        rel();
        for (int n = 0; n < 4; n++) begin
            cfg.consec_sel = 2'(n);
            for (int k = 0; k <= n; k++) begin
                chk(warn_n, 1'b1);
                conv(8'h08, 8'h20);
            end
            chk(warn_n, 1'b0);
            rel();
        end
        $display("warning done");
        cfg.warning_pin_function_select = 1'b1;
        conv(8'h40, 8'h20);
        chk({ot_n, warn_n}, 8'h02);
        conv(8'h37, 8'h20);
        chk(warn_n, 1'b0);
        hyst_wr = 1'b1;
        tick(1);
        hyst_wr = 1'b0;
        conv(8'h37, 8'h20);
        chk(warn_n, 1'b1);
        $display("alarm2 done");
        bm.start();
        bm.wbyte(8'h0B, ack);
        chk({ack, hs_mode}, 8'h01);
        bm.start();
        bm.wbyte(OWN_W, ack);
        chk(ack, 1'b1);
        bm.stop();
        tick(10);
        chk(hs_mode, 1'b0);
        bm.start();
        bm.wbyte(8'h0B, ack);
        bm.start();
        for (int i = 7; i >= 0; i--) bm.bit_io(OWN_W[i], ack);
        tick(100);
        chk({dut_oe, hs_mode}, 8'h03);
        tick(2700);
        chk({dut_oe, hs_mode}, 8'h00);
        bm.stop();
        addr_rd(OWN_W);
        chk(ack, 1'b1);
        addr_sel = 1'b1;
        addr_rd(OWN_W | 8'h02);
        chk(ack, 1'b1);
        $display("bus done");
        results();
    end
endmodule
